// [rtl/ipbus_pkg.sv]
package ipbus_pkg;

    // ------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int WCNT_W = 16;
    localparam logic [DATA_W-1:0] DATA_IDLE = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_IDLE = 16'h0000;
    localparam logic [WCNT_W-1:0] WCNT_ZERO = 16'h0000;
    localparam logic [WCNT_W-1:0] WCNT_ONE  = 16'h0001;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0]        SYNC_LEN  = 4'h1;

    // ------------------------------------------------------------
    // Request and answer groups
    // ------------------------------------------------------------
    typedef struct packed {
        logic              write;
        logic              low_byte;
        logic              high_byte;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] data;
    } pio_req_t;

    typedef struct packed {
        logic              done;
        logic [DATA_W-1:0] rdata;
    } pio_rsp_t;

    typedef struct packed {
        logic [WCNT_W-1:0] count;
        logic              source;
        logic [DATA_W-1:0] wdata;
    } dma_req_t;

    // ------------------------------------------------------------
    // Two-way handshake pin
    // ------------------------------------------------------------
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drv_t;

endpackage : ipbus_pkg

// [rtl/ipbus_sync.sv]
`timescale 1ns/100ps
module ipbus_sync
    import ipbus_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;
    logic meta_d;
    logic out_q;
    logic out_d;

    always_comb begin
        meta_d = din;
        out_d  = meta_q;
    end

    // Reset to one: every handshake line rests high when undriven.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            meta_q <= 1'b1;
            out_q  <= 1'b1;
        end else begin
            meta_q <= meta_d;
            out_q  <= out_d;
        end
    end

    assign dout = out_q;
endmodule : ipbus_sync

// [rtl/ipbus_host.sv]
`timescale 1ns/100ps
// Function
// - Sixteen-bit true-level byte address bus
// - Registers reached by address decode only
// - Data lines active low, value driven under enable
// - Handshakes active low and wired OR, except ready, which is active high
// - Write strobe low only with valid data
// - DMA write held until acknowledge low
// - Source holds data in final cycle; a DMA word from the host drops its data with the write strobe
// - Ready low inserts wait states
// - Destination pulls acknowledge on capture
// - No new word while acknowledge low
// - Hold request held low during DMA
module ipbus_host
    import ipbus_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire pio_req_t          PIO_REQ,
    input  wire logic              PIO_VALID,
    output pio_rsp_t               PIO_RSP,
    output logic                   PIO_BUSY,
    input  wire dma_req_t          DMA_REQ,
    input  wire logic              DMA_START,
    output logic                   DMA_DONE,
    output logic                   DMA_ACTIVE,
    output logic [ADDR_W-1:0]      BUS_BYTE_ADDRESS_O,
    output logic                   BUS_BYTE_ADDRESS_OE,
    input  wire logic [DATA_W-1:0] BUS_DATA_N_I,
    output logic [DATA_W-1:0]      BUS_DATA_N_O,
    output logic                   BUS_DATA_N_OE,
    input  wire logic              BUS_WRITE_STROBE_N_I,
    output pin_drv_t               BUS_WRITE_STROBE_N,
    output pin_drv_t               BUS_READ_STROBE_N,
    input  wire logic              BUS_READY_I,
    input  wire logic              BUS_DMA_ACK_N_I,
    output pin_drv_t               BUS_CYCLE_SYNC_N,
    output pin_drv_t               BUS_HOLD_REQUEST_N,
    input  wire logic              BUS_HOLD_GRANT_N_I,
    output pin_drv_t               BUS_HOLD_GRANT_N,
    output pin_drv_t               BUS_DMA_GO_N
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic ready_s;
    logic ack_n_s;
    logic grant_n_s;
    logic wr_n_s;

    ipbus_sync u_sync_ready (.CLK(CLK), .RST_N(RST_N), .din(BUS_READY_I),          .dout(ready_s));
    ipbus_sync u_sync_ack   (.CLK(CLK), .RST_N(RST_N), .din(BUS_DMA_ACK_N_I),      .dout(ack_n_s));
    ipbus_sync u_sync_grant (.CLK(CLK), .RST_N(RST_N), .din(BUS_HOLD_GRANT_N_I),   .dout(grant_n_s));
    ipbus_sync u_sync_wr    (.CLK(CLK), .RST_N(RST_N), .din(BUS_WRITE_STROBE_N_I), .dout(wr_n_s));

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_SYNC, S_SETUP, S_STROBE, S_WAIT, S_LAST,
        S_HREQ, S_GO, S_DWR, S_DACK, S_DREL, S_DEND
    } state_t;

    state_t            state_q, state_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              addr_oe_q, addr_oe_d;
    logic [DATA_W-1:0] dout_q, dout_d;
    logic              dout_oe_q, dout_oe_d;
    logic              wr_q, wr_d;
    logic              rd_q, rd_d;
    logic              sync_q, sync_d;
    logic              hreq_q, hreq_d;
    logic              go_q, go_d;
    logic              is_wr_q, is_wr_d;
    logic [BYTE_W-1:0] low_buf_q, low_buf_d;
    logic [WCNT_W-1:0] wcnt_q, wcnt_d;
    logic              dsrc_q, dsrc_d;
    pio_rsp_t          rsp_q, rsp_d;
    logic              busy_q, busy_d;
    logic              done_q, done_d;

    // Active-high logic one becomes a low level on the lines.
    function automatic logic [DATA_W-1:0] to_bus(input logic [DATA_W-1:0] v);
        to_bus = ~v;
    endfunction : to_bus

    always_comb begin
        state_d   = state_q;
        addr_d    = addr_q;
        addr_oe_d = addr_oe_q;
        dout_d    = dout_q;
        dout_oe_d = dout_oe_q;
        wr_d      = wr_q;
        rd_d      = rd_q;
        sync_d    = 1'b0;
        hreq_d    = hreq_q;
        go_d      = go_q;
        is_wr_d   = is_wr_q;
        low_buf_d = low_buf_q;
        wcnt_d    = wcnt_q;
        dsrc_d    = dsrc_q;
        rsp_d     = rsp_q;
        rsp_d.done = 1'b0;
        busy_d    = busy_q;
        done_d    = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (DMA_START) begin
                    hreq_d = 1'b1;
                    wcnt_d = DMA_REQ.count;
                    dsrc_d = DMA_REQ.source;
                    busy_d = 1'b1;
                    state_d = S_HREQ;
                end else if (PIO_VALID) begin
                    // Only the even low byte of a write is parked; the bus cycle waits for the high byte.
                    if (PIO_REQ.write && PIO_REQ.low_byte && !PIO_REQ.high_byte) begin
                        low_buf_d = PIO_REQ.data;
                        rsp_d.done = 1'b1;
                    end else begin
                        addr_d    = PIO_REQ.addr;
                        addr_oe_d = 1'b1;
                        is_wr_d   = PIO_REQ.write;
                        sync_d    = 1'b1;
                        busy_d    = 1'b1;
                        state_d   = S_SYNC;
                        if (PIO_REQ.write) begin
                            dout_d    = to_bus({PIO_REQ.data, low_buf_q});
                            dout_oe_d = 1'b1;
                        end
                    end
                end
            end
            S_SYNC: begin
                // The ready synchroniser lags two edges; one quiet cycle lets it show this target first.
                state_d = S_SETUP;
            end
            S_SETUP: begin
                if (is_wr_q) begin
                    wr_d = 1'b1;
                end else begin
                    rd_d = 1'b1;
                end
                state_d = S_STROBE;
            end
            S_STROBE: begin
                // Ready seen low during the strobe cycle stretches it.
                if (!ready_s) begin
                    state_d = S_WAIT;
                end else begin
                    rsp_d.rdata = ~BUS_DATA_N_I;
                    wr_d        = 1'b0;
                    rd_d        = 1'b0;
                    state_d     = S_LAST;
                end
            end
            S_WAIT: begin
                if (ready_s) begin
                    rsp_d.rdata = ~BUS_DATA_N_I;
                    wr_d        = 1'b0;
                    rd_d        = 1'b0;
                    state_d     = S_LAST;
                end
            end
            S_LAST: begin
                rsp_d.done  = 1'b1;
                addr_oe_d = 1'b0;
                dout_oe_d = 1'b0;
                busy_d    = 1'b0;
                state_d   = S_IDLE;
            end
            S_HREQ: begin
                if (!grant_n_s) begin
                    if (wcnt_q == WCNT_ZERO) begin
                        state_d = S_DEND;
                    end else begin
                        go_d    = 1'b1;
                        state_d = S_GO;
                    end
                end
            end
            S_GO: begin
                if (ack_n_s || !dsrc_q) begin
                    if (dsrc_q) begin
                        dout_d    = to_bus(DMA_REQ.wdata);
                        dout_oe_d = 1'b1;
                        wr_d      = 1'b1;
                    end
                    state_d = S_DWR;
                end
            end
            S_DWR: begin
                if (!ack_n_s) begin
                    wr_d   = 1'b0;
                    dout_oe_d = 1'b0;
                    wcnt_d = wcnt_q - WCNT_ONE;
                    state_d = S_DACK;
                end
            end
            S_DACK: begin
                if (wcnt_q == WCNT_ZERO) begin
                    go_d    = 1'b0;
                    state_d = S_DEND;
                end else begin
                    state_d = S_DREL;
                end
            end
            S_DREL: begin
                if (ack_n_s) begin
                    state_d = S_GO;
                end
            end
            S_DEND: begin
                hreq_d = 1'b0;
                if (grant_n_s) begin
                    busy_d  = 1'b0;
                    done_d  = 1'b1;
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q   <= S_IDLE;
            addr_q    <= ADDR_IDLE;
            addr_oe_q <= 1'b0;
            dout_q    <= DATA_IDLE;
            dout_oe_q <= 1'b0;
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            sync_q    <= 1'b0;
            hreq_q    <= 1'b0;
            go_q      <= 1'b0;
            is_wr_q   <= 1'b0;
            low_buf_q <= BYTE_ZERO;
            wcnt_q    <= WCNT_ZERO;
            dsrc_q    <= 1'b0;
            rsp_q     <= '0;
            busy_q    <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            addr_q    <= addr_d;
            addr_oe_q <= addr_oe_d;
            dout_q    <= dout_d;
            dout_oe_q <= dout_oe_d;
            wr_q      <= wr_d;
            rd_q      <= rd_d;
            sync_q    <= sync_d;
            hreq_q    <= hreq_d;
            go_q      <= go_d;
            is_wr_q   <= is_wr_d;
            low_buf_q <= low_buf_d;
            wcnt_q    <= wcnt_d;
            dsrc_q    <= dsrc_d;
            rsp_q     <= rsp_d;
            busy_q    <= busy_d;
            done_q    <= done_d;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Handshake lines are open drain: the output is always low and only the enable moves; address and data drive their value.
    assign BUS_BYTE_ADDRESS_O    = addr_q;
    assign BUS_BYTE_ADDRESS_OE   = addr_oe_q;
    assign BUS_DATA_N_O          = dout_q;
    assign BUS_DATA_N_OE         = dout_oe_q;
    assign BUS_WRITE_STROBE_N    = '{o: 1'b0, oe: wr_q};
    assign BUS_READ_STROBE_N     = '{o: 1'b0, oe: rd_q};
    assign BUS_CYCLE_SYNC_N      = '{o: 1'b0, oe: sync_q};
    assign BUS_HOLD_REQUEST_N    = '{o: 1'b0, oe: hreq_q};
    // The host never drives hold grant: the enable is tied low and the grant comes from outside.
    assign BUS_HOLD_GRANT_N      = '{o: 1'b0, oe: 1'b0};
    assign BUS_DMA_GO_N          = '{o: 1'b0, oe: go_q};
    assign PIO_RSP               = rsp_q;
    assign PIO_BUSY              = busy_q;
    assign DMA_DONE              = done_q;
    assign DMA_ACTIVE            = go_q;
endmodule : ipbus_host

// [verif/ipbus_host_monitor.sv]
`timescale 1ns/100ps
module ipbus_host_monitor
    import ipbus_pkg::*;
(
    input wire logic     CLK,
    input wire logic     RST_N,
    input wire logic     BUS_BYTE_ADDRESS_OE,
    input wire logic     BUS_READY_I,
    input wire logic     BUS_DMA_ACK_N_I,
    input wire logic     BUS_HOLD_GRANT_N_I,
    input wire pin_drv_t BUS_WRITE_STROBE_N,
    input wire pin_drv_t BUS_READ_STROBE_N,
    input wire pin_drv_t BUS_CYCLE_SYNC_N,
    input wire pin_drv_t BUS_HOLD_REQUEST_N,
    input wire pin_drv_t BUS_DMA_GO_N
);
    wire w   = BUS_WRITE_STROBE_N.oe;
    wire r   = BUS_READ_STROBE_N.oe;
    wire g   = BUS_DMA_GO_N.oe;
    wire h   = BUS_HOLD_REQUEST_N.oe;
    wire s   = BUS_CYCLE_SYNC_N.oe;
    wire rdy = BUS_READY_I;
    wire ack = BUS_DMA_ACK_N_I;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Ready is seen through two flops, so the past values checked lie behind that lag.
    chk_wr_single: assert property ($rose(w) && !g && $past(rdy) && $past(rdy, 2) |=> !w)
        else $error("write strobe too long");
    chk_rd_single: assert property ($rose(r) && $past(rdy) && $past(rdy, 2) |=> !r)
        else $error("read strobe too long");
    chk_wr_after_rdy: assert property ($fell(w) && !g |-> $past(rdy) && $past(rdy, 2))
        else $error("write ended early");
    chk_rd_after_rdy: assert property ($fell(r) |-> $past(rdy) && $past(rdy, 2))
        else $error("read ended early");
    chk_rd_pio_only: assert property (r |-> !g && !h) else $error("read strobe during transfer");
    chk_hold_quiet: assert property (!BUS_HOLD_GRANT_N_I |-> !BUS_BYTE_ADDRESS_OE && !r)
        else $error("bus driven in hold");
    chk_go_granted: assert property ($rose(g) |-> h && !$past(BUS_HOLD_GRANT_N_I, 2))
        else $error("go without grant");
    chk_go_in_hold: assert property (g |-> h) else $error("go without request");
    chk_wr_until_ack: assert property ($fell(w) && g |-> !$past(ack) && !$past(ack, 2))
        else $error("word dropped");
    chk_no_busy_word: assert property ($rose(w) && g |-> $past(ack)) else $error("word while busy");
    chk_sync_one: assert property ($rose(s) |=> !s) else $error("sync pulse too long");
    cover property ($fell(g));
    cover property (r && !rdy);
    cover property ($rose(w) && g);
endmodule : ipbus_host_monitor

bind ipbus_host ipbus_host_monitor mon (.*);

// [verif/ipbus_peer.sv]
`timescale 1ns/100ps
module ipbus_peer
    import ipbus_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RST_N,
    input  wire logic [3:0]        waits,
    input  wire logic              ext,
    input  wire logic [DATA_W-1:0] word,
    input  wire logic              addr_oe,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic              hreq_n,
    input  wire logic              go_n,
    output logic                   ready,
    output logic [DATA_W-1:0]      data_n,
    output logic                   pwr,
    output logic                   ack_n,
    output logic                   grant_n
);
    logic [3:0] wait_q;
    logic [3:0] hold_q;
    logic [2:0] grant_q;
    // Decode is immediate, so a slow board stalls from the first address cycle.
    assign ready   = !(addr_oe && wait_q != 4'h0);
    assign data_n  = rd_n ? 16'hFFFF : ~word;
    assign pwr     = ext && !go_n && ack_n;
    assign grant_n = grant_q[2];
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wait_q  <= 4'h0;
            hold_q  <= 4'h0;
            grant_q <= 3'h7;
            ack_n   <= 1'b1;
        end else begin
            grant_q <= {grant_q[1:0], hreq_n};
            wait_q  <= !addr_oe ? waits : wait_q - {3'h0, wait_q != 4'h0};
            if (ack_n && !wr_n && !go_n) begin
                ack_n  <= 1'b0;
                hold_q <= 4'h4;
            end else if (hold_q != 4'h0) begin
                hold_q <= hold_q - 4'h1;
            end else if (wr_n) begin
                ack_n <= 1'b1;
            end
        end
    end
endmodule : ipbus_peer

// [verif/internal_processor_bus_handshake_tb.sv]
`timescale 1ns/100ps
module internal_processor_bus_handshake_tb
    import ipbus_pkg::*;
;
    logic        CLK = 1'b0, RST_N = 1'b0, PIO_VALID = 1'b0, DMA_START = 1'b0, ext = 1'b0;
    pio_req_t    PIO_REQ = '0;
    dma_req_t    DMA_REQ = '0;
    pio_rsp_t    PIO_RSP;
    logic        PIO_BUSY, DMA_DONE, DMA_ACTIVE, BUS_BYTE_ADDRESS_OE, BUS_DATA_N_OE, pwr, grant_n;
    logic [15:0] BUS_BYTE_ADDRESS_O, BUS_DATA_N_O, data_n, ea, ew, word = 16'h0;
    logic [3:0]  waits = 4'h0;
    logic [31:0] seed = 32'h17, r, q;
    pin_drv_t    BUS_WRITE_STROBE_N, BUS_READ_STROBE_N, BUS_CYCLE_SYNC_N;
    pin_drv_t    BUS_HOLD_REQUEST_N, BUS_HOLD_GRANT_N, BUS_DMA_GO_N;
    wire         BUS_READY_I, BUS_DMA_ACK_N_I;
    int          n_mismatch = 0, num_checks = 0, acks = 0, gos = 0, k;
    // ----------------------------------------------------------------
    // Wired lines: low wins, released lines rest high
    // ----------------------------------------------------------------
    wire wr_n   = !(BUS_WRITE_STROBE_N.oe || pwr);
    wire rd_n   = !BUS_READ_STROBE_N.oe;
    wire go_n   = !BUS_DMA_GO_N.oe;
    wire hreq_n = !BUS_HOLD_REQUEST_N.oe;
    wire BUS_WRITE_STROBE_N_I = wr_n;
    wire BUS_HOLD_GRANT_N_I   = grant_n && !BUS_HOLD_GRANT_N.oe;
    wire [15:0] BUS_DATA_N_I  = BUS_DATA_N_OE ? BUS_DATA_N_O : data_n;
    ipbus_host uut (.*);
    ipbus_peer peer (.*, .addr_oe(BUS_BYTE_ADDRESS_OE), .ready(BUS_READY_I), .ack_n(BUS_DMA_ACK_N_I));
    always #2.5 CLK = !CLK;
    always @(negedge BUS_DMA_ACK_N_I) acks++;
    always @(negedge go_n) gos++;
    always @(negedge CLK) begin
        if (RST_N && !(rd_n && wr_n) && go_n) check(BUS_BYTE_ADDRESS_O, ea);
        if (RST_N && !wr_n && (go_n || !ext)) check(BUS_DATA_N_I, ~ew);
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    task automatic programmed_io(input logic wr, input logic lo, input logic hi, input logic [7:0] d);
        int i;
        PIO_REQ   <= '{wr, lo, hi, ea, d};
        PIO_VALID <= 1'b1;
        @(posedge CLK);
        PIO_VALID <= 1'b0;
        @(negedge CLK);
        check(16'(PIO_BUSY), 16'(!(wr && lo && !hi)));
        for (i = 0; i < 80 && PIO_RSP.done !== 1'b1; i++) @(negedge CLK);
        check(PIO_RSP.done, 1'b1);
        check(16'(PIO_BUSY), 16'h0000);
        @(posedge CLK);
    endtask : programmed_io
    task automatic dma(input logic [15:0] n, input logic src);
        int          i, a0, g0;
        logic [31:0] v;
        v  = rnd();
        ew = v[15:0];
        ext       <= !src;
        DMA_REQ   <= '{n, src, ew};
        DMA_START <= 1'b1;
        @(posedge CLK);
        DMA_START <= 1'b0;
        @(negedge CLK);
        check(16'(PIO_BUSY), 16'h0001);
        a0 = acks;
        g0 = gos;
        for (i = 0; i < 900 && DMA_DONE !== 1'b1; i++) @(negedge CLK);
        check(DMA_DONE, 1'b1);
        check(16'(DMA_ACTIVE), 16'h0000);
        check(16'(acks - a0), n);
        check(16'(gos - g0), {15'h0, n != 16'h0});
        @(posedge CLK);
    endtask : dma
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        dma(16'h0000, 1'b1);
        dma(16'h0005, 1'b1);
        dma(16'h0003, 1'b0);
        for (k = 0; k < 24; k++) begin
            r = rnd();
            q = rnd();
            waits <= {1'b0, r[18:16]};
            word  <= r[15:0];
            ea = q[31:16];
            case (r[21:20])
                2'h0: dma({14'h0, r[23:22]}, r[24]);
                2'h1: begin
                    programmed_io(1'b0, 1'b1, 1'b1, 8'h00);
                    check(PIO_RSP.rdata, r[15:0]);
                end
                default: begin
                    ew = q[15:0];
                    programmed_io(1'b1, 1'b1, 1'b0, ew[7:0]);
                    programmed_io(1'b1, 1'b0, 1'b1, ew[15:8]);
                end
            endcase
        end
        conclude();
    end
    initial begin
        #150000;
        n_mismatch++;
        conclude();
    end
endmodule : internal_processor_bus_handshake_tb
